// [hdl/random_access_slot_timing.sv]
// Terminal random access preamble and message timing sequencer
`include "rach_timing_regs.svh"
`default_nettype none
module random_access_slot_timing #(
    parameter int SLOT_CYC      = `SLOT_CYC,
    parameter int OFFSET_CYC    = `SLOT_OFFSET_CYC,
    parameter int AI_TO_PRE_CYC = `AI_TO_PRE_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Received downlink frame boundary pulse
    input  wire logic       frame_start,
    // Configuration
    input  wire logic       aich_timing,
    input  wire logic [7:0] usable_mask,
    // Access request from upper layer
    input  wire logic       pre_req,
    // Acquisition indicator result
    input  wire logic       ai_valid,
    input  wire logic       ai_ack,
    // Timing outputs
    output logic            pre_go,
    output logic            msg_go,
    output logic            ai_expect,
    output logic [2:0]      ul_slot_idx,
    output logic            busy
);
    typedef struct packed {
        rach_timing_pkg::rach_state_e st;
        logic [2:0]                   since_pre;
        logic                         have_pre;
        rach_timing_pkg::slot_idx_t   pre_idx;
        logic                         ai_run;
        rach_timing_pkg::long_cnt_t   ai_cnt;
        logic                         ai_pos;
        logic                         pre_go;
        logic                         msg_go;
        logic                         ai_expect;
        rach_timing_pkg::slot_idx_t   ul_idx;
    } seq_s;

    seq_s       q, d;
    slot_if     sif ();
    logic [2:0] gap_m1;
    logic       spacing_ok;
    logic       ai_gap_ok;
    logic       slot_ok;

    // Slot grid
    access_slot_grid #(
        .SLOT_CYC   (SLOT_CYC),
        .OFFSET_CYC (OFFSET_CYC)
    ) u_grid (
        .clk_sys     (clk_sys),
        .srst        (srst),
        .frame_start (frame_start),
        .sif         (sif)
    );

    assign sif.aich_timing = aich_timing;

    // Minimum intervals and slot usability
    assign gap_m1     = 3'(`SLOT_GAP_SHORT - 1) + {2'b00, aich_timing};
    assign spacing_ok = q.since_pre >= gap_m1;
    // One short: the go pulse is registered a cycle after this decision
    assign ai_gap_ok  = q.ai_cnt >= rach_timing_pkg::long_cnt_t'(AI_TO_PRE_CYC - 1);
    assign slot_ok    = sif.ul_start && usable_mask[sif.ul_idx];

    // Sequencer
    always_comb begin
        d           = q;
        d.pre_go    = 1'b0;
        d.msg_go    = 1'b0;
        d.ai_expect = 1'b0;
        // Slots elapsed since the last preamble, saturating
        if (sif.ul_start && q.since_pre != 3'h7) begin
            d.since_pre = q.since_pre + 3'h1;
        end
        // Time since the expected indicator started, saturating
        if (q.ai_run && !ai_gap_ok) begin
            d.ai_cnt = q.ai_cnt + 18'h0_0001;
        end
        // Paired downlink slot of the last preamble opens the indicator
        if (q.st == rach_timing_pkg::ST_AI_WAIT && sif.dl_start &&
            sif.dl_idx == q.pre_idx && !q.ai_run) begin
            d.ai_expect = 1'b1;
            d.ai_run    = 1'b1;
            d.ai_cnt    = '0;
        end
        case (q.st)
            rach_timing_pkg::ST_IDLE: begin
                if (pre_req) begin
                    d.st = rach_timing_pkg::ST_PRE;
                end
            end
            rach_timing_pkg::ST_PRE: begin
                if (!pre_req) begin
                    d.st       = rach_timing_pkg::ST_IDLE;
                    d.have_pre = 1'b0;
                end else if (slot_ok && spacing_ok &&
                             (!(q.have_pre || q.ai_run) || ai_gap_ok)) begin
                    d.pre_go    = 1'b1;
                    d.since_pre = '0;
                    d.have_pre  = 1'b1;
                    d.pre_idx   = sif.ul_idx;
                    d.ul_idx    = sif.ul_idx;
                    d.ai_run    = 1'b0;
                    d.ai_cnt    = '0;
                    d.ai_pos    = 1'b0;
                    d.st        = rach_timing_pkg::ST_AI_WAIT;
                end
            end
            rach_timing_pkg::ST_AI_WAIT: begin
                if (q.ai_run && ai_valid) begin
                    d.ai_pos = ai_ack;
                end
                if (q.ai_run && ai_valid && ai_ack) begin
                    d.st = rach_timing_pkg::ST_MSG;
                end else if (q.ai_run && spacing_ok) begin
                    d.st = rach_timing_pkg::ST_PRE; // Retry after negative or no answer
                end
            end
            rach_timing_pkg::ST_MSG: begin
                if (slot_ok && spacing_ok && ai_gap_ok) begin
                    d.msg_go   = 1'b1;
                    d.ul_idx   = sif.ul_idx;
                    d.have_pre = 1'b0;
                    d.ai_run   = 1'b0;
                    d.st       = rach_timing_pkg::ST_IDLE;
                end
            end
            default: begin
                d.st = rach_timing_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign pre_go      = q.pre_go;
    assign msg_go      = q.msg_go;
    assign ai_expect   = q.ai_expect;
    assign ul_slot_idx = q.ul_idx;
    assign busy        = q.st != rach_timing_pkg::ST_IDLE;
endmodule : random_access_slot_timing
`default_nettype wire

// [hdl/rach_timing_regs.svh]
// Timing constants for the random access slot timing block
`ifndef RACH_TIMING_REGS_SVH
`define RACH_TIMING_REGS_SVH

// Clock rate in MHz
`define CLK_MHZ          50
// Access slot length, uplink/downlink offset, indicator-to-preamble time (us)
`define SLOT_US          1250
`define SLOT_OFFSET_US   500
`define AI_TO_PRE_US     2000
// Preamble-to-indicator times (us) for setting 0 and 1
`define PRE_TO_AI0_US    1750
`define PRE_TO_AI1_US    3000
// Derived cycle counts; all come out exact at 50 MHz
`define SLOT_CYC         (`SLOT_US * `CLK_MHZ)
`define SLOT_OFFSET_CYC  (`SLOT_OFFSET_US * `CLK_MHZ)
`define AI_TO_PRE_CYC    (`AI_TO_PRE_US * `CLK_MHZ)
// Access slots per radio frame, and slot spacing for setting 0
`define SLOTS_PER_FRAME  8
`define SLOT_GAP_SHORT   3
// Index lead from the downlink slot an uplink slot starts in to its paired downlink slot, setting 0
`define PAIR_LEAD_SHORT  2

`endif

// [hdl/rach_timing_pkg.sv]
// Types shared by the random access slot timing modules
`default_nettype none
package rach_timing_pkg;
    typedef logic [2:0]  slot_idx_t;
    typedef logic [16:0] slot_cnt_t;
    typedef logic [17:0] long_cnt_t;
    typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_AI_WAIT, ST_MSG} rach_state_e;
endpackage : rach_timing_pkg
`default_nettype wire

// [hdl/slot_if.sv]
// Access slot grid signals passed between the grid and the sequencer
`default_nettype none
interface slot_if;
    logic                        dl_start;
    logic                        ul_start;
    rach_timing_pkg::slot_idx_t  dl_idx;
    rach_timing_pkg::slot_idx_t  ul_idx;
    logic                        aich_timing;
    modport grid (output dl_start, ul_start, dl_idx, ul_idx, input aich_timing);
    modport user (input dl_start, ul_start, dl_idx, ul_idx, output aich_timing);
endinterface : slot_if
`default_nettype wire

// [hdl/access_slot_grid.sv]
// Downlink and uplink access slot grid generator
`include "rach_timing_regs.svh"
`default_nettype none
module access_slot_grid #(
    parameter int SLOT_CYC   = `SLOT_CYC,
    parameter int OFFSET_CYC = `SLOT_OFFSET_CYC
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Received primary control channel frame boundary
    input  wire logic frame_start,
    // Grid out
    slot_if.grid      sif
);
    typedef struct packed {
        rach_timing_pkg::slot_cnt_t cnt;
        rach_timing_pkg::slot_idx_t dl_idx;
        rach_timing_pkg::slot_idx_t ul_idx;
        logic                       dl_start;
        logic                       ul_start;
    } grid_s;

    grid_s q, d;

    // Slot counter, restarted on each frame boundary
    always_comb begin
        d          = q;
        d.dl_start = 1'b0;
        d.ul_start = 1'b0;
        if (frame_start) begin
            d.cnt      = '0;
            d.dl_idx   = '0;
            d.dl_start = 1'b1;
        end else if (q.cnt == rach_timing_pkg::slot_cnt_t'(SLOT_CYC - 1)) begin
            d.cnt      = '0;
            d.dl_idx   = q.dl_idx + 3'h1;
            d.dl_start = 1'b1;
        end else begin
            d.cnt = q.cnt + 17'h0_0001;
        end
        // Uplink boundary sits a fixed offset before the next downlink boundary
        if (!frame_start &&
            q.cnt == rach_timing_pkg::slot_cnt_t'(SLOT_CYC - OFFSET_CYC - 1)) begin
            d.ul_start = 1'b1;
            d.ul_idx   = q.dl_idx + 3'(`PAIR_LEAD_SHORT) + {2'b00, sif.aich_timing};
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sif.dl_start = q.dl_start;
    assign sif.ul_start = q.ul_start;
    assign sif.dl_idx   = q.dl_idx;
    assign sif.ul_idx   = q.ul_idx;
endmodule : access_slot_grid
`default_nettype wire

// [tb/random_access_slot_timing_props.sv]
// Assertions on the random access slot timing ports
`default_nettype none
module random_access_slot_timing_props #(
    parameter int SLOT_CYC      = 40,
    parameter int OFFSET_CYC    = 16,
    parameter int AI_TO_PRE_CYC = 64
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       srst,
    // Watched inputs
    input wire logic       aich_timing,
    input wire logic [7:0] usable_mask,
    // Watched outputs
    input wire logic       pre_go,
    input wire logic       msg_go,
    input wire logic       ai_expect,
    input wire logic [2:0] ul_slot_idx,
    input wire logic       busy
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SAT = 16 * SLOT_CYC;
    int cnt_pre;
    int cnt_ai;
    int gap;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Minimum spacing for the current setting
    assign gap = aich_timing ? 4 * SLOT_CYC : 3 * SLOT_CYC;
    // Cycles since last preamble and last indicator slot
    always_ff @(posedge clk_sys) begin
        cnt_pre <= srst ? SAT : pre_go ? 1 : cnt_pre < SAT ? cnt_pre + 1 : SAT;
        cnt_ai  <= srst ? SAT : ai_expect ? 1 : cnt_ai < SAT ? cnt_ai + 1 : SAT;
    end
    chk_ai_pairing: assert property (ai_expect |->
        cnt_pre == (aich_timing ? 2 * SLOT_CYC : SLOT_CYC) + OFFSET_CYC)
        else $error("indicator slot off its preamble");
    chk_pre_spacing: assert property (pre_go |-> cnt_pre >= gap)
        else $error("preambles too close");
    chk_pre_grid: assert property (pre_go && cnt_pre < SAT |-> cnt_pre % SLOT_CYC == 0)
        else $error("preamble off slot grid");
    chk_msg_spacing: assert property (msg_go |-> cnt_pre >= gap && cnt_pre % SLOT_CYC == 0)
        else $error("message start misplaced");
    chk_pre_after_ai: assert property (pre_go |-> cnt_ai >= AI_TO_PRE_CYC)
        else $error("preamble too soon after indicator");
    chk_msg_after_ai: assert property (msg_go |-> cnt_ai >= AI_TO_PRE_CYC)
        else $error("message too soon after indicator");
    chk_slot_usable: assert property (pre_go || msg_go |=> usable_mask[ul_slot_idx])
        else $error("unusable slot used");
    chk_msg_ends: assert property (msg_go |-> !busy ##1 !msg_go)
        else $error("no idle after message");
endmodule : random_access_slot_timing_props
bind random_access_slot_timing random_access_slot_timing_props #(.SLOT_CYC(SLOT_CYC),
    .OFFSET_CYC(OFFSET_CYC), .AI_TO_PRE_CYC(AI_TO_PRE_CYC)) props (.clk_sys, .srst,
    .aich_timing, .usable_mask, .pre_go, .msg_go, .ai_expect, .ul_slot_idx, .busy);
`default_nettype wire

// [tb/base_station_model.sv]
// Base station model: frame boundaries and acquisition indicators
`default_nettype none
module base_station_model #(
    parameter int SLOT_CYC = 40
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Indicator slot; reply 0 none, 1 refuse, 2 grant
    input  wire logic       ai_expect,
    input  wire logic [1:0] reply_mode,
    // Downlink
    output logic            frame_start,
    output logic            ai_valid,
    output logic            ai_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    int fcnt;
    // Frame every eight access slots, downlink slots aligned to it
    always_ff @(posedge clk_sys) begin
        fcnt        <= (srst || fcnt == 8 * SLOT_CYC - 1) ? 0 : fcnt + 1;
        frame_start <= !srst && fcnt == 0;
    end
    // Indicator at the paired downlink slot start; ack toggles when unused
    always_ff @(posedge clk_sys) begin
        ai_valid <= !srst && ai_expect && reply_mode != 2'h0;
        ai_ack   <= srst ? 1'b0 : (ai_expect && reply_mode != 2'h0) ? reply_mode == 2'h2 : !ai_ack;
    end
endmodule : base_station_model
`default_nettype wire

// [tb/random_access_slot_timing_bench.sv]
// Self-checking bench for the random access slot timing block
`default_nettype none
module random_access_slot_timing_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SLOT = 40;
    logic       clk_sys = 1'b0, srst = 1'b1, aich_timing = 1'b0, pre_req = 1'b0;
    logic [7:0] usable_mask = 8'hff;
    logic [1:0] reply_mode = 2'h2;
    logic       frame_start, ai_valid, ai_ack, pre_go, msg_go, ai_expect, busy;
    logic [2:0] ul_slot_idx, idx_pre, idx_msg;
    int         fails = 0, n_compared = 0, cyc = 0, n_pre = 0, n_msg = 0, t_pre, t_old, t_msg;
    always #10 clk_sys = ~clk_sys;
    random_access_slot_timing #(.SLOT_CYC(SLOT), .OFFSET_CYC(16), .AI_TO_PRE_CYC(64)) dut (
        .clk_sys, .srst, .frame_start, .aich_timing, .usable_mask, .pre_req,
        .ai_valid, .ai_ack, .pre_go, .msg_go, .ai_expect, .ul_slot_idx, .busy);
    base_station_model #(.SLOT_CYC(SLOT)) bs (
        .clk_sys, .srst, .ai_expect, .reply_mode, .frame_start, .ai_valid, .ai_ack);
    // Stamp each preamble and message start
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (pre_go === 1'b1) begin
            t_old <= t_pre;
            t_pre <= cyc;
            idx_pre <= ul_slot_idx;
            n_pre <= n_pre + 1;
        end
        if (msg_go === 1'b1) begin
            t_msg <= cyc;
            idx_msg <= ul_slot_idx;
            n_msg <= n_msg + 1;
        end
    end
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (exp !== got) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic wait_for(ref int cnt, input int target);
        for (int i = 0; i < 2000 && cnt < target; i++) #20;
    endtask : wait_for
    // Granted access: message spacing and slot indices
    task automatic s_access(logic tm, logic [7:0] mask, int slots);
        aich_timing = tm;
        usable_mask = mask;
        reply_mode = 2'h2;
        pre_req = 1'b1;
        wait_for(n_msg, n_msg + 1);
        pre_req = 1'b0;
        check("pre to msg", slots * SLOT, t_msg - t_pre);
        check("pre slot usable", 1, mask[idx_pre]);
        check("msg slot", (idx_pre + slots) % 8, idx_msg);
        #40;
        check("busy idle", 0, busy);
    endtask : s_access
    // Refused or unanswered access: retry spacing, then abort
    task automatic s_retry(logic tm, logic [1:0] mode);
        aich_timing = tm;
        usable_mask = 8'hff;
        reply_mode = mode;
        pre_req = 1'b1;
        wait_for(n_pre, n_pre + 2);
        pre_req = 1'b0;
        check("retry spacing", (3 + tm) * SLOT, t_pre - t_old);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) #20;
        check("busy after abort", 0, busy);
    endtask : s_retry
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        #2 srst = 1'b0;
        #20;
        s_access(1'b0, 8'hff, 3);
        s_access(1'b1, 8'hff, 4);
        s_retry(1'b0, 2'h1);
        s_retry(1'b1, 2'h0);
        s_access(1'b0, 8'h20, 8);
        conclude();
    end
    // Watchdog
    initial begin
        #200000;
        fails++;
        conclude();
    end
endmodule : random_access_slot_timing_bench
`default_nettype wire
